// file: core/oscc_pkg.sv
// oscc_pkg: register offsets, field layout, reset values and mode codes
// assumes: shared by the oscillator control top, its settle timer, the assertions and the bench
package oscc_pkg;
  localparam logic [7:0] OSCC_ADDR_EXT = 8'hb1; // external oscillator control
  localparam logic [7:0] OSCC_ADDR_INT = 8'hb2; // internal oscillator control
  localparam logic [7:0] OSCC_ADDR_TRIM = 8'hb3; // internal oscillator trim
  localparam logic [7:0] OSCC_EXT_RESET = 8'h00; // external control reset
  localparam logic [5:0] OSCC_INT_LOW_PATTERN = 6'h0f; // fixed low bits
  localparam logic [6:0] OSCC_TRIM_DEFAULT = 7'h40; // part-specific default
  localparam int OSCC_BIT_ON = 7; // internal enable / dither / stable bit
  localparam int OSCC_BIT_OK = 6; // frequency ready bit
  localparam int OSCC_BIT_RSV = 3; // reserved external bit
  localparam int OSCC_SEL_HI = 6; // mode field top
  localparam int OSCC_SEL_LO = 4; // mode field bottom
  localparam int OSCC_BIAS_HI = 2; // bias field top
  localparam int OSCC_TRIM_HI = 6; // trim field top
  // mode codes of the external circuit
  typedef enum logic [2:0] {
    OSCC_MODE_OFF0 = 3'h0,
    OSCC_MODE_OFF1 = 3'h1,
    OSCC_MODE_CMOS = 3'h2,
    OSCC_MODE_CMOS_DIV2 = 3'h3,
    OSCC_MODE_RC = 3'h4,
    OSCC_MODE_CAP = 3'h5,
    OSCC_MODE_XTAL = 3'h6,
    OSCC_MODE_XTAL_DIV2 = 3'h7
  } oscc_mode_type;
  // system clock source codes
  localparam logic [2:0] OSCC_SRC_INTERNAL = 3'h0;
  localparam logic [2:0] OSCC_SRC_EXTERNAL = 3'h1;
  // settle counts in clock cycles (125 MHz)
  localparam int OSCC_CLK_MHZ = 125;
  localparam int OSCC_INT_SETTLE_NS = 800; // internal lock settle time
  localparam int OSCC_INT_SETTLE_CYC = (OSCC_INT_SETTLE_NS * OSCC_CLK_MHZ
                                        + 999) / 1000;
  localparam int OSCC_CNT_W = 12; // settle counter width
endpackage : oscc_pkg

// file: core/oscc_ctl_if.sv
// oscc_ctl_if: settings and status between top and settle timer
// assumes: one clock domain
interface oscc_ctl_if;
  logic run; // oscillator requested
  logic restart; // setting changed, restart settle
  logic [11:0] settle; // settle count in cycles
  logic done; // settled
  modport ctl (output run, output restart, output settle, input done);
  modport tmr (input run, input restart, input settle, output done);
endinterface : oscc_ctl_if

// file: core/oscc_settle.sv
// oscc_settle: counts settle time after an oscillator start or change
// assumes: synchronous reset, one clock
module oscc_settle
  import oscc_pkg::*;
(
  input wire logic clock, // system clock
  input wire logic rst_n, // sync reset, active low
  oscc_ctl_if.tmr ctl // settings and status
);
  logic [OSCC_CNT_W-1:0] count; // cycles since start
  // count up while running, clear on stop or change
  always_ff @(posedge clock) begin
    if (!rst_n || !ctl.run || ctl.restart) begin
      count <= '0;
      ctl.done <= 1'b0;
    end else if (count >= ctl.settle) begin
      ctl.done <= 1'b1;
    end else begin
      count <= count + 1'b1;
    end
  end
endmodule : oscc_settle

// file: core/oscc_regs.sv
// oscc_regs: oscillator control and status special function registers
// assumes: sfr bus with address, write strobe and read data, one clock;
// external oscillator stable indication arrives synchronous to the clock
// Operation
// - internal oscillator runs while enable bit set
// - bit six reports internal frequency ready
// - low six bits read fixed 001111b
// - trim bit seven enables spread dithering
// - larger trim value lowers internal frequency
// - trim resets to default, dither off
// - external stable flag reads oscillator stable
// - cmos modes always read stable zero
// - mode field selects external circuit type
// - codes 011, 111 add divide-by-two stage
// - external bit three reads zero
// - three-bit bias selects eight current levels
// - source select picks internal or external
module oscc_regs
  import oscc_pkg::*;
#(
  parameter logic [6:0] TRIM_RESET = OSCC_TRIM_DEFAULT // part trim value
) (
  input wire logic clock, // system clock
  input wire logic rst_n, // sync reset, active low
  input wire logic [7:0] sfr_addr, // sfr address
  input wire logic sfr_wr, // write strobe
  input wire logic [7:0] sfr_wdata, // write data
  input wire logic sfr_rd, // read strobe
  input wire logic ext_osc_detect, // external oscillation seen stable
  input wire logic [2:0] sysclk_source_sel, // system clock source code
  output logic [7:0] sfr_rdata, // registered read data
  output logic internal_osc_on, // internal oscillator run
  output logic dither_enable, // spread spectrum on
  output logic [6:0] internal_trim, // trim, larger is slower
  output logic [2:0] ext_osc_select, // external circuit mode
  output logic ext_div2, // external clock halved
  output logic [2:0] ext_bias_level, // external bias current
  output logic sysclk_use_internal, // system clock from internal
  output logic sysclk_use_external // system clock from external
);
  logic internal_freq_ok; // internal at programmed frequency
  logic ext_osc_stable; // external valid flag
  logic next_ext_stable; // next value of external valid flag
  logic [7:0] next_rdata; // read mux
  logic int_restart; // trim or enable write
  oscc_ctl_if int_ctl (); // internal settle timer link

  // true for mode codes that drive the external clock through a halver
  function automatic logic oscc_is_div2(input logic [2:0] mode);
    oscc_is_div2 = (mode == OSCC_MODE_CMOS_DIV2) ||
                   (mode == OSCC_MODE_XTAL_DIV2);
  endfunction : oscc_is_div2

  // true for modes whose valid detector never reports stable
  function automatic logic oscc_no_detect(input logic [2:0] mode);
    oscc_no_detect = (mode == OSCC_MODE_OFF0) ||
                     (mode == OSCC_MODE_OFF1) ||
                     (mode == OSCC_MODE_CMOS) ||
                     (mode == OSCC_MODE_CMOS_DIV2);
  endfunction : oscc_no_detect

  // internal enable: written whole; low pattern is not stored
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      internal_osc_on <= 1'b0;
    end else if (sfr_wr && sfr_addr == OSCC_ADDR_INT) begin
      internal_osc_on <= sfr_wdata[OSCC_BIT_ON];
    end
  end

  // trim and dither register
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      dither_enable <= 1'b0;
      internal_trim <= TRIM_RESET;
    end else if (sfr_wr && sfr_addr == OSCC_ADDR_TRIM) begin
      dither_enable <= sfr_wdata[OSCC_BIT_ON];
      internal_trim <= sfr_wdata[OSCC_TRIM_HI:0];
    end
  end

  // external control: mode, halver and bias
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      ext_osc_select <= OSCC_EXT_RESET[OSCC_SEL_HI:OSCC_SEL_LO];
      ext_div2 <= 1'b0;
      ext_bias_level <= OSCC_EXT_RESET[OSCC_BIAS_HI:0];
    end else if (sfr_wr && sfr_addr == OSCC_ADDR_EXT) begin
      ext_osc_select <= sfr_wdata[OSCC_SEL_HI:OSCC_SEL_LO];
      ext_div2 <= oscc_is_div2(sfr_wdata[OSCC_SEL_HI:OSCC_SEL_LO]);
      ext_bias_level <= sfr_wdata[OSCC_BIAS_HI:0];
    end
  end

  // internal oscillator settle: restart on any change of enable or trim
  assign int_restart = sfr_wr && (sfr_addr == OSCC_ADDR_TRIM ||
                                  sfr_addr == OSCC_ADDR_INT);
  assign int_ctl.run = internal_osc_on;
  assign int_ctl.restart = int_restart;
  assign int_ctl.settle = OSCC_CNT_W'(OSCC_INT_SETTLE_CYC);

  oscc_settle u_settle (
    .clock(clock),
    .rst_n(rst_n),
    .ctl(int_ctl)
  );

  // ready flag, held low while disabled
  assign internal_freq_ok = internal_osc_on && int_ctl.done;

  // external stable flag: zero while off or in cmos modes
  always_comb begin
    if (oscc_no_detect(ext_osc_select)) begin
      next_ext_stable = 1'b0;
    end else begin
      next_ext_stable = ext_osc_detect;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      ext_osc_stable <= 1'b0;
    end else if (sfr_wr && sfr_addr == OSCC_ADDR_EXT) begin
      ext_osc_stable <= 1'b0; // new mode restarts detection
    end else begin
      ext_osc_stable <= next_ext_stable;
    end
  end

  // read data mux; unmapped addresses read zero
  always_comb begin
    next_rdata = 8'h00;
    case (sfr_addr)
      OSCC_ADDR_INT: begin
        next_rdata = {internal_osc_on, internal_freq_ok,
                      OSCC_INT_LOW_PATTERN};
      end
      OSCC_ADDR_TRIM: begin
        next_rdata = {dither_enable, internal_trim};
      end
      OSCC_ADDR_EXT: begin
        next_rdata = {ext_osc_stable, ext_osc_select, 1'b0,
                      ext_bias_level};
      end
      default: begin
        next_rdata = 8'h00; // unmapped
      end
    endcase
  end

  // registered read data, loaded on read strobe
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      sfr_rdata <= 8'h00;
    end else if (sfr_rd) begin
      sfr_rdata <= next_rdata;
    end
  end

  // system clock source decode
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      sysclk_use_internal <= 1'b0;
      sysclk_use_external <= 1'b0;
    end else begin
      sysclk_use_internal <= sysclk_source_sel == OSCC_SRC_INTERNAL;
      sysclk_use_external <= sysclk_source_sel == OSCC_SRC_EXTERNAL;
    end
  end
endmodule : oscc_regs

// file: sim/oscc_asserts.sv
// oscc_asserts: port checks of the register block
// assumes: bound onto oscc_regs, one clock
module oscc_asserts
  import oscc_pkg::*;
(
  input wire logic clock, rst_n, sfr_wr, sfr_rd, // bus strobes
  input wire logic [7:0] sfr_addr, sfr_wdata, sfr_rdata, // bus data
  input wire logic internal_osc_on, dither_enable, ext_div2, // controls
  input wire logic [6:0] internal_trim, // trim
  input wire logic [2:0] ext_osc_select, sysclk_source_sel, // modes
  input wire logic sysclk_use_internal // source decode
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  wire logic wr_int = sfr_wr && sfr_addr == OSCC_ADDR_INT; // write 0xb2
  wire logic rd_int = sfr_rd && sfr_addr == OSCC_ADDR_INT; // read 0xb2
  wire logic rd_ext = sfr_rd && sfr_addr == OSCC_ADDR_EXT; // read 0xb1
  osc_on_a: assert property (wr_int |=>
    internal_osc_on == $past(sfr_wdata[7])) else $error("enable lost");
  trim_wr_a: assert property (sfr_wr && sfr_addr == OSCC_ADDR_TRIM |=>
    {dither_enable, internal_trim} == $past(sfr_wdata)) else $error("trim");
  mode_wr_a: assert property (sfr_wr && sfr_addr == OSCC_ADDR_EXT |=>
    ext_osc_select == $past(sfr_wdata[6:4])) else $error("mode lost");
  half_clk_a: assert property (ext_div2 ==
    (ext_osc_select[1:0] == 2'h3)) else $error("divide stage");
  src_pick_a: assert property (rst_n |=> sysclk_use_internal ==
    ($past(sysclk_source_sel) == OSCC_SRC_INTERNAL)) else $error("source");
  low_fixed_a: assert property (rd_int |=>
    sfr_rdata[5:0] == OSCC_INT_LOW_PATTERN) else $error("low bits");
  rsv_zero_a: assert property (rd_ext |=> !sfr_rdata[3])
    else $error("reserved bit");
  cmos_zero_a: assert property (rd_ext && !ext_osc_select[2] |=>
    !sfr_rdata[7]) else $error("stable flag");
  rdy_off_a: assert property (rd_int && !internal_osc_on |=>
    !sfr_rdata[6]) else $error("ready flag");
  cover property (rd_int ##1 sfr_rdata[6]);
  cover property (ext_div2);
  cover property (rd_ext ##1 sfr_rdata[7]);
endmodule : oscc_asserts

// file: sim/oscc_xosc_model.sv
// oscc_xosc_model: external oscillator, stable DLY cycles after a change
// assumes: mode comes from the block; cmos input also looks stable
module oscc_xosc_model #(
  parameter int DLY = 12 // settle cycles
) (
  input wire logic clock, // system clock
  input wire logic [2:0] mode, // external circuit mode
  output logic detect // oscillation seen stable
);
  logic [2:0] last = 3'h0; // mode of the previous cycle
  int cnt = 0; // cycles since the last mode change
  // any mode change restarts the settle count
  always @(posedge clock) begin
    last <= mode;
    cnt <= (mode != last) ? 0 : cnt + 1;
  end
  assign detect = mode[2:1] != 2'h0 && cnt >= DLY;
endmodule : oscc_xosc_model

// file: sim/oscc_regs_bench.sv
// oscc_regs_bench: random and corner register traffic on oscc_regs
// assumes: partner model feeds the external stable input
module oscc_regs_bench
  import oscc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [6:0] TRIM = 7'h2a; // bench trim reset value
  logic clock = 1'h0, rst_n = 1'h0, sfr_wr = 1'h0, sfr_rd = 1'h0;
  logic [7:0] sfr_addr = 8'h00, sfr_wdata = 8'h00, sfr_rdata;
  logic [2:0] sysclk_source_sel = 3'h0, ext_osc_select, ext_bias_level;
  logic internal_osc_on, dither_enable, ext_div2, ext_osc_detect;
  logic sysclk_use_internal, sysclk_use_external;
  logic [6:0] internal_trim;
  logic [15:0] lfsr = 16'h2369; // random state
  int error_cnt = 0, n_checks = 0, cyc = 0;
  oscc_regs #(.TRIM_RESET(TRIM)) oscc_regs_i (.*);
  oscc_xosc_model oscc_xosc_model_i (.clock(clock),
    .mode(ext_osc_select), .detect(ext_osc_detect));
  always #4 clock = ~clock;
  // cut a hang short
  always @(posedge clock) begin
    cyc++;
    if (cyc == 6000) begin
      error_cnt++;
      final_report();
    end
  end
  function automatic logic [15:0] next_rand(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : next_rand
  // settled external control readback
  function automatic logic [7:0] exp_ext(input logic [2:0] m, b);
    return {m[2], m, 1'h0, b};
  endfunction : exp_ext
  task automatic chk(input logic [7:0] got, exp);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  // one write or read, driven at the falling edge
  task automatic bus(input logic w, input logic [7:0] a, d);
    sfr_wr = w;
    sfr_rd = !w;
    sfr_addr = a;
    sfr_wdata = d;
    @(negedge clock);
    sfr_wr = 1'h0;
    sfr_rd = 1'h0;
    sysclk_source_sel = lfsr[2:0];
    lfsr = next_rand(lfsr);
    @(negedge clock);
  endtask : bus
  task automatic final_report;
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : final_report
  initial begin
    logic [7:0] d;
    logic [2:0] b;
    repeat (5) @(negedge clock);
    rst_n = 1'h1;
    bus(0, OSCC_ADDR_EXT, 8'h00);
    chk(sfr_rdata, OSCC_EXT_RESET);
    bus(0, OSCC_ADDR_TRIM, 8'h00);
    chk(sfr_rdata, {1'h0, TRIM});
    bus(0, OSCC_ADDR_INT, 8'h00);
    chk(sfr_rdata, 8'h0f);
    // enable by read-modify-write, keeping the fixed low pattern
    bus(1, OSCC_ADDR_INT, sfr_rdata | 8'h80);
    bus(0, OSCC_ADDR_INT, 8'h00);
    chk(sfr_rdata, 8'h8f);
    repeat (110) @(negedge clock);
    bus(0, OSCC_ADDR_INT, 8'h00);
    chk(sfr_rdata, 8'hcf);
    bus(1, OSCC_ADDR_INT, sfr_rdata & 8'h3f);
    bus(0, OSCC_ADDR_INT, 8'h00);
    chk(sfr_rdata, 8'h0f);
    for (int i = 0; i < 8; i++) begin
      // trim kept at or above the nominal value: at or below nominal speed
      d = (i == 0) ? 8'h7f : {lfsr[7], lfsr[6:0] | TRIM};
      bus(1, OSCC_ADDR_TRIM, d);
      chk({dither_enable, internal_trim}, d);
      chk({6'h00, sysclk_use_internal, sysclk_use_external},
        {6'h00, sysclk_source_sel == OSCC_SRC_INTERNAL,
        sysclk_source_sel == OSCC_SRC_EXTERNAL});
      bus(0, OSCC_ADDR_TRIM, 8'h00);
      chk(sfr_rdata, d);
    end
    // every mode, read-only flag written as one, reserved bit as zero
    for (int m = 0; m < 8; m++) begin
      b = lfsr[2:0];
      bus(1, OSCC_ADDR_EXT, {1'h1, m[2:0], 1'h0, b});
      chk({ext_div2, ext_osc_select, 1'h0, ext_bias_level},
        {m[1:0] == 2'h3, m[2:0], 1'h0, b});
      repeat (20) @(negedge clock);
      bus(0, OSCC_ADDR_EXT, 8'h00);
      chk(sfr_rdata, exp_ext(m[2:0], b));
    end
    bus(1, 8'hb4, 8'hff);
    bus(0, 8'hb4, 8'h00);
    chk(sfr_rdata, 8'h00);
    final_report();
  end
endmodule : oscc_regs_bench
bind oscc_regs oscc_asserts oscc_asserts_i (.*);
